// file: rtl/asf_forwarder.sv
// Function
// - 9600 baud, 8 data, no parity, 1 stop
// - after CR, next characters start new string
// - drop control characters other than CR
// - forward each string at once, no pulse
// - never echo received characters back
// - 2-D strings accept up to 1556 bytes
// - bar code strings accept up to 50 characters
// - status 7 when error status enabled
// - output in normal reading result format
`default_nettype none
module asf_forwarder
  import asf_pkg::*;
#(
  // bit time in core cycles; a short value keeps bench runs brief
  parameter int unsigned BIT_CYC_P = BIT_CYC
)
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // auxiliary serial port
  input wire logic aux_rxd_in,
  output logic aux_txd_out,
  // configuration levels
  input wire logic mode_2d_in,
  input wire logic err_status_en_in,
  // host result stream
  output logic host_valid_out,
  input wire logic host_ready_in,
  output logic [7:0] host_data_out,
  output logic host_last_out,
  output logic host_aux_out,
  output logic [3:0] diagnostic_status_field_out,
  output logic overrun_out
);
  typedef enum logic [1:0] {
    ASF_IDLE = 2'b00,
    ASF_START = 2'b01,
    ASF_DATA = 2'b10,
    ASF_STOP = 2'b11
  } asf_rx_e;

  logic [2:0] sync_q;  // three-stage pin synchroniser
  logic rxd_q;  // filtered line level
  asf_rx_e st_q;  // receiver state
  logic [BCNT_W-1:0] bcnt_q;  // bit timer
  logic [2:0] bit_q;  // data bit index
  logic [7:0] shf_q;  // shift register
  logic chr_stb_q;  // one-cycle: character received
  logic [7:0] chr_q;  // received character
  logic [LEN_W-1:0] len_q;  // content length so far
  logic over_q;  // string exceeded its limit or lost a character to a full buffer
  logic wr_vld;  // word offered to buffer
  logic [BUF_W-1:0] wr_word;
  logic wr_rdy;
  logic rd_vld;
  logic [BUF_W-1:0] rd_word;
  logic rd_rdy;
  logic is_ctrl;
  logic [LEN_W-1:0] limit;

  // echo is never produced: the line idles high from reset on
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) aux_txd_out <= 1'b1;
    else aux_txd_out <= 1'b1;
  end

  // pin crosses three flops; change counts when stages 2 and 3 agree
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_q <= 3'h7;
      rxd_q <= 1'b1;
    end else begin
      sync_q <= {sync_q[1:0], aux_rxd_in};
      if (sync_q[1] == sync_q[2]) rxd_q <= sync_q[2];
    end
  end

  // receiver: fixed 9600 8N1 framing, sampled mid-bit
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= ASF_IDLE;
      bcnt_q <= '0;
      bit_q <= 3'h0;
      shf_q <= 8'h00;
      chr_stb_q <= 1'b0;
      chr_q <= 8'h00;
    end else begin
      chr_stb_q <= 1'b0;
      case (st_q)
        ASF_IDLE: begin
          // falling edge starts a character
          if (!rxd_q) begin
            st_q <= ASF_START;
            bcnt_q <= BCNT_W'(BIT_CYC_P / 2 - 1);
          end
        end
        ASF_START: begin
          if (bcnt_q != '0) begin
            bcnt_q <= bcnt_q - 1'b1;
          end else if (rxd_q) begin
            // glitch, not a real start bit
            st_q <= ASF_IDLE;
          end else begin
            st_q <= ASF_DATA;
            bit_q <= 3'h0;
            bcnt_q <= BCNT_W'(BIT_CYC_P - 1);
          end
        end
        ASF_DATA: begin
          if (bcnt_q != '0) begin
            bcnt_q <= bcnt_q - 1'b1;
          end else begin
            // lsb first, eight bits, no parity
            shf_q <= {rxd_q, shf_q[7:1]};
            bcnt_q <= BCNT_W'(BIT_CYC_P - 1);
            if (bit_q == 3'(DATA_BITS - 1)) st_q <= ASF_STOP;
            bit_q <= bit_q + 3'h1;
          end
        end
        ASF_STOP: begin
          if (bcnt_q != '0) begin
            bcnt_q <= bcnt_q - 1'b1;
          end else begin
            // one stop bit; a low stop bit is a framing error, dropped
            st_q <= ASF_IDLE;
            if (rxd_q) begin
              chr_stb_q <= 1'b1;
              chr_q <= shf_q;
            end
          end
        end
        default: st_q <= ASF_IDLE;
      endcase
    end
  end

  // content filter and string framing
  assign is_ctrl = (chr_q < CHR_SPACE) || (chr_q == CHR_DEL);
  assign limit = mode_2d_in ? LEN_W'(MAX_2D_LEN)
                            : LEN_W'(MAX_1D_LEN);
  always_comb begin
    wr_vld = 1'b0;
    wr_word = {1'b0, 1'b0, chr_q};
    if (chr_stb_q) begin
      if (chr_q == CHR_CR) begin
        // terminator closes the string; empty strings still mark the end
        wr_vld = 1'b1;
        wr_word = {over_q, 1'b1, CHR_CR};
      end else if (!is_ctrl && !over_q && (len_q < limit)) begin
        wr_vld = 1'b1;
        wr_word = {1'b0, 1'b0, chr_q};
      end
    end
  end

  // length count; a character arriving while the buffer is full is lost
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      len_q <= '0;
      over_q <= 1'b0;
    end else if (chr_stb_q) begin
      if (chr_q == CHR_CR) begin
        len_q <= '0;
        over_q <= 1'b0;
      end else if (!is_ctrl) begin
        if (len_q >= limit || !wr_rdy) over_q <= 1'b1;
        else len_q <= len_q + 1'b1;
      end
    end
  end

  // back-pressure from the host reaches the buffer, never the line
  asf_buf2 i_asf_buf2 (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(wr_vld),
    .in_ready_out(wr_rdy),
    .in_data_in(wr_word),
    .out_valid_out(rd_vld),
    .out_ready_in(rd_rdy),
    .out_data_out(rd_word)
  );

  // output register; forwarding needs no reading pulse
  assign rd_rdy = !host_valid_out || host_ready_in;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      host_valid_out <= 1'b0;
      host_data_out <= 8'h00;
      host_last_out <= 1'b0;
      host_aux_out <= 1'b0;
      diagnostic_status_field_out <= 4'h0;
      overrun_out <= 1'b0;
    end else if (rd_rdy) begin
      host_valid_out <= rd_vld;
      host_data_out <= rd_word[7:0];
      host_last_out <= rd_word[8];
      overrun_out <= rd_word[9];
      host_aux_out <= rd_vld;
      diagnostic_status_field_out <= err_status_en_in ? DIAG_AUX
                                                      : 4'h0;
    end
  end

  sequence s_cr_taken;
    chr_stb_q && chr_q == CHR_CR;
  endsequence
  sequence s_len_clear;
    ##1 len_q == '0;
  endsequence

  AST_CR_RESTARTS: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in) s_cr_taken |-> s_len_clear)
    else $error("length not cleared after terminator");
  AST_CTRL_DROPPED: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in) (chr_stb_q && is_ctrl && chr_q != CHR_CR)
      |-> !wr_vld)
    else $error("control character stored");
  AST_NO_ECHO: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in) aux_txd_out)
    else $error("aux line driven low");
  AST_FWD_PROMPT: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in) (rd_vld && !host_valid_out) |=> host_valid_out)
    else $error("string not forwarded at once");
  AST_LEN_LIMIT: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in) len_q <= LEN_W'(MAX_2D_LEN))
    else $error("2-D length exceeded");
  AST_LEN_1D: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in) (!mode_2d_in && wr_vld && !wr_word[8])
      |-> len_q < LEN_W'(MAX_1D_LEN))
    else $error("bar code length exceeded");
  AST_DIAG: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in) (rd_rdy && rd_vld && err_status_en_in)
      |=> diagnostic_status_field_out == DIAG_AUX)
    else $error("diagnostic status not 7");
  AST_STOP_BIT: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in) chr_stb_q |-> $past(rxd_q))
    else $error("character taken without stop bit");
  AST_HOLD: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in) (host_valid_out && !host_ready_in)
      |=> host_valid_out && $stable(host_data_out))
    else $error("host word changed while stalled");
endmodule : asf_forwarder
`default_nettype wire

// file: rtl/asf_pkg.sv
`default_nettype none
package asf_pkg;
  // core clock and link timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned BAUD = 9600;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
  localparam int unsigned HALF_CYC = BIT_CYC / 2;
  localparam int unsigned BCNT_W = 15;
  // character format: 8 data bits, no parity, 1 stop bit
  localparam int unsigned DATA_BITS = 8;
  // character codes
  localparam logic [7:0] CHR_CR = 8'h0D;
  localparam logic [7:0] CHR_SPACE = 8'h20;
  localparam logic [7:0] CHR_DEL = 8'h7F;
  // string length limits
  localparam int unsigned MAX_2D_LEN = 1556;
  localparam int unsigned MAX_1D_LEN = 50;
  localparam int unsigned LEN_W = 11;
  // diagnostic status value for forwarded strings
  localparam logic [3:0] DIAG_AUX = 4'h7;
  // two-entry buffer
  localparam int unsigned BUF_DEPTH = 2;
  localparam int unsigned BUF_W = 10;
endpackage : asf_pkg
`default_nettype wire

// file: rtl/asf_buf2.sv
`default_nettype none
// two-entry skid buffer; full and empty are honest
module asf_buf2
  import asf_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [BUF_W-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [BUF_W-1:0] out_data_out
);
  logic [BUF_W-1:0] mem_q [BUF_DEPTH];  // entry storage
  logic wr_q;  // write index
  logic rd_q;  // read index
  logic [1:0] cnt_q;  // occupancy
  logic push;
  logic pop;

  assign push = in_valid_in && (cnt_q != 2'h2);
  assign pop = out_valid_out && out_ready_in;
  assign in_ready_out = (cnt_q != 2'h2);
  assign out_valid_out = (cnt_q != 2'h0);
  assign out_data_out = mem_q[rd_q];

  // storage written by index
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  // pointers and count
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  AST_NO_OVERFLOW: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in) cnt_q <= 2'h2)
    else $error("buffer count above two");
endmodule : asf_buf2
`default_nettype wire

// file: sim/asf_term_model.sv
`default_nettype none
// sending terminal: types each key at once, ends strings with one cr
module asf_term_model
  import asf_pkg::*;
#(
  // bit time in core cycles, matched to the block under test
  parameter int unsigned BIT_CYC_P = BIT_CYC
)
(
  // serial line toward the block
  output logic rxd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // bit time in ns at the 4 ns core period
  localparam int BIT_NS = int'(BIT_CYC_P * 4);
  // the line idles high between characters
  initial rxd_out = 1'b1;
  // one character: start, eight data bits lsb first, one stop
  task automatic send_char(input logic [7:0] ch);
    int i;
    rxd_out = 1'b0;
    #(BIT_NS);
    for (i = 0; i < DATA_BITS; i++) begin
      rxd_out = ch[i];
      #(BIT_NS);
    end
    rxd_out = 1'b1;
    #(BIT_NS);
  endtask : send_char
  // content only, null framing, then a single cr
  task automatic send_string(input string s);
    int i;
    for (i = 0; i < s.len(); i++) begin
      send_char(8'(s[i]));
    end
    send_char(CHR_CR);
  endtask : send_string
endmodule : asf_term_model
`default_nettype wire

// file: sim/test_aux_serial_string_forwarder.sv
`default_nettype none
module test_aux_serial_string_forwarder
  import asf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and block inputs
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic aux_rxd_in;
  logic mode_2d_in = 1'b0;
  logic err_status_en_in = 1'b0;
  logic host_ready_in = 1'b1;
  // block outputs
  logic aux_txd_out;
  logic host_valid_out;
  logic [7:0] host_data_out;
  logic host_last_out;
  logic host_aux_out;
  logic [3:0] diagnostic_status_field_out;
  logic overrun_out;
  // bookkeeping
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [14:0] got_q [$]; // overrun, last, aux, status, data
  // free running core clock, 4 ns period
  always #2 core_clk_in = ~core_clk_in;
  // short bit time: a real 9600 baud char takes over 2.6e5 cycles
  localparam int unsigned TB_BIT_CYC = 32;
  asf_term_model #(.BIT_CYC_P(TB_BIT_CYC)) i_asf_term_model (
    .rxd_out(aux_rxd_in));
  asf_forwarder #(.BIT_CYC_P(TB_BIT_CYC)) i_asf_forwarder (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .aux_rxd_in(aux_rxd_in), .aux_txd_out(aux_txd_out),
    .mode_2d_in(mode_2d_in), .err_status_en_in(err_status_en_in),
    .host_valid_out(host_valid_out), .host_ready_in(host_ready_in),
    .host_data_out(host_data_out), .host_last_out(host_last_out),
    .host_aux_out(host_aux_out),
    .diagnostic_status_field_out(diagnostic_status_field_out),
    .overrun_out(overrun_out));
  // verdict and end of run
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // capture every accepted word; the echo line must stay idle
  always @(posedge core_clk_in) begin
    if (host_valid_out === 1'b1 && host_ready_in === 1'b1) begin
      got_q.push_back({overrun_out, host_last_out, host_aux_out,
                       diagnostic_status_field_out, host_data_out});
      if (aux_txd_out !== 1'b1) begin
        bad_count++;
        $display("CHECK FAILED %0t echo seen", $time);
      end
    end
  end
  // hang guard: about 115 chars of 320 cycles need under 40k cycles
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 60_000) begin
      bad_count++;
      $display("CHECK FAILED %0t run timed out", $time);
      wrap_up();
    end
  end
  // compare the next accepted word, waiting a bounded time for it
  task automatic expect_word(input logic [7:0] d, input logic last,
                             input logic [3:0] diag, input logic ovr);
    logic [14:0] w;
    int n;
    n = 0;
    while (got_q.size() == 0 && n < 2000) begin
      @(negedge core_clk_in);
      n++;
    end
    compares++;
    if (got_q.size() == 0) begin
      bad_count++;
      $display("CHECK FAILED %0t word missing", $time);
    end else begin
      w = got_q.pop_front();
      if (w !== {ovr, last, 1'b1, diag, d}) begin
        bad_count++;
        $display("CHECK FAILED %0t word %h wrong", $time, w);
      end
    end
  endtask : expect_word
  // control chars dropped, cr closes, next string starts fresh
  task automatic scen_strings();
    @(negedge core_clk_in);
    err_status_en_in = 1'b1;
    i_asf_term_model.send_char(8'h41);
    i_asf_term_model.send_char(8'h01);
    i_asf_term_model.send_string("B");
    expect_word(8'h41, 1'b0, DIAG_AUX, 1'b0);
    expect_word(8'h42, 1'b0, DIAG_AUX, 1'b0);
    expect_word(CHR_CR, 1'b1, DIAG_AUX, 1'b0);
    i_asf_term_model.send_string("C");
    expect_word(8'h43, 1'b0, DIAG_AUX, 1'b0);
    expect_word(CHR_CR, 1'b1, DIAG_AUX, 1'b0);
  endtask : scen_strings
  // host stalls over a whole string; nothing may be lost or change
  task automatic scen_stall();
    int n;
    @(negedge core_clk_in);
    err_status_en_in = 1'b0;
    mode_2d_in = 1'b1;
    host_ready_in = 1'b0;
    i_asf_term_model.send_string("XY");
    repeat (100) @(negedge core_clk_in);
    compares++;
    if (host_valid_out !== 1'b1 || host_data_out !== 8'h58) begin
      bad_count++;
      $display("CHECK FAILED %0t stalled word not held", $time);
    end
    host_ready_in = 1'b1;
    expect_word(8'h58, 1'b0, 4'h0, 1'b0);
    expect_word(8'h59, 1'b0, 4'h0, 1'b0);
    expect_word(CHR_CR, 1'b1, 4'h0, 1'b0);
    n = got_q.size();
    compares++;
    if (n != 0) begin
      bad_count++;
      $display("CHECK FAILED %0t extra words", $time);
    end
  endtask : scen_stall
  // empty string, then the bar code limit, then the same 51 chars accepted in 2-D mode
  task automatic scen_limits();
    int i;
    @(negedge core_clk_in);
    mode_2d_in = 1'b0;
    i_asf_term_model.send_char(CHR_CR);
    expect_word(CHR_CR, 1'b1, 4'h0, 1'b0);
    // one character past the bar code limit must be cut off
    for (i = 0; i < MAX_1D_LEN + 1; i++) begin
      i_asf_term_model.send_char(8'h4D);
    end
    i_asf_term_model.send_char(CHR_CR);
    for (i = 0; i < MAX_1D_LEN; i++) begin
      expect_word(8'h4D, 1'b0, 4'h0, 1'b0);
    end
    expect_word(CHR_CR, 1'b1, 4'h0, 1'b1);
    @(negedge core_clk_in);
    // the same length is legal for 2-D content
    mode_2d_in = 1'b1;
    for (i = 0; i < MAX_1D_LEN + 1; i++) begin
      i_asf_term_model.send_char(8'h4E);
    end
    i_asf_term_model.send_char(CHR_CR);
    for (i = 0; i < MAX_1D_LEN + 1; i++) begin
      expect_word(8'h4E, 1'b0, 4'h0, 1'b0);
    end
    expect_word(CHR_CR, 1'b1, 4'h0, 1'b0);
    compares++;
    if (got_q.size() != 0) begin
      bad_count++;
      $display("CHECK FAILED %0t extra words after limits", $time);
    end
  endtask : scen_limits
  // main sequence
  initial begin
    repeat (20) @(negedge core_clk_in);
    reset_n_in = 1'b1;
    repeat (10) @(negedge core_clk_in);
    scen_strings();
    scen_stall();
    scen_limits();
    wrap_up();
  end
endmodule : test_aux_serial_string_forwarder
`default_nettype wire
